// File: common/ssid_regs_pkg.sv
package ssid_regs_pkg;

  // configuration offsets, byte addresses
  localparam logic [7:0] OFF_SUBSYS_IDENT_WORD = 8'h40;
  localparam logic [7:0] OFF_SUBSYS_VENDOR     = 8'h40;
  localparam logic [7:0] OFF_SUBSYS_IDENT      = 8'h42;
  localparam logic [7:0] OFF_LEGACY_BASE       = 8'h44;
  localparam logic [7:0] OFF_SYSTEM_SETUP      = 8'h80;
  localparam logic [7:0] OFF_DWORD_MASK        = 8'hfc;

  // field positions
  localparam int unsigned IDENT_WRITE_LOCK_BIT = 5;
  localparam int unsigned LEGACY_FIXED_BIT     = 0;

  // values after reset
  localparam logic [15:0] SUBSYS_VENDOR_RESET = 16'h5a3c; // arbitrary value
  localparam logic [15:0] SUBSYS_IDENT_RESET  = 16'hc3a5; // arbitrary value
  localparam logic [31:0] LEGACY_BASE_RESET   = 32'h0000_0001;
  localparam logic [31:0] SYSTEM_SETUP_RESET  = 32'h0800_9060;

  // host-writable bits of the system setup control, legacy base and identity registers
  localparam logic [31:0] SYSTEM_SETUP_WMASK  = 32'hf77f_c07b;
  localparam logic [31:0] LEGACY_BASE_WMASK   = 32'hffff_fffe;
  localparam logic [31:0] ALL_BITS_WMASK      = 32'hffff_ffff;

  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // byte-enable merge, gated by a per-bit write mask
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] wr_v,
                                              input logic [3:0]  be,
                                              input logic [31:0] wmask);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~bm) | (wr_v & bm);
  endfunction

  function automatic logic dword_hit(input logic [7:0] offset, input logic [7:0] target);
    return (offset & OFF_DWORD_MASK) == target;
  endfunction

endpackage

// File: common/legacy_decode_if.sv
`timescale 1ns/10ps
interface legacy_decode_if;
  logic [31:0] base;
  logic [31:0] io_addr;
  logic        io_valid;
  logic        index_hit;
  logic        data_hit;

  modport regs (output base, output io_addr, output io_valid, input index_hit, input data_hit);
  modport decoder (input base, input io_addr, input io_valid, output index_hit, output data_hit);
endinterface

// File: logic/legacy_io_decode.sv
`timescale 1ns/10ps
module legacy_io_decode (
  legacy_decode_if.decoder dec
);
  logic [31:0] index_addr;
  logic [31:0] data_addr;

  // bit 0 of the base reads as 1, so the pair sits on base with bit 0 dropped
  assign index_addr    = {dec.base[31:1], 1'b0};
  assign data_addr     = {dec.base[31:1], 1'b1};
  assign dec.index_hit = dec.io_valid && (dec.io_addr == index_addr);
  assign dec.data_hit  = dec.io_valid && (dec.io_addr == data_addr);
endmodule

// File: logic/subsystem_ident_legacy_base_regs.sv
`timescale 1ns/10ps
// How it works
// - identity writes only while write lock clear
// - write lock comes up set after reset
// - only global reset clears these registers
// - eeprom loads both identity values on a load strobe, only once its presence pin is synchronised high
// - base with bit 0 dropped decodes index, base itself data
// - base placeable anywhere in 32-bit space
// - base bit 0 reads one, rest writable
// - one base register shared by both functions
// - system control at 80h, resets 08009060h
module subsystem_ident_legacy_base_regs (
  input  wire  logic        core_clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        cfg_req_i,
  input  wire  logic        cfg_write_i,
  input  wire  logic        cfg_func_i,
  input  wire  logic [7:0]  cfg_offset_i,
  input  wire  logic [3:0]  cfg_be_i,
  input  wire  logic [31:0] cfg_wdata_i,
  output logic              cfg_ack_o,
  output logic [31:0]       cfg_rdata_o,
  input  wire  logic        eeprom_present_i,
  input  wire  logic        eeprom_load_i,
  input  wire  logic [15:0] eeprom_vendor_i,
  input  wire  logic [15:0] eeprom_ident_i,
  input  wire  logic        io_valid_i,
  input  wire  logic [31:0] io_addr_i,
  output logic              index_hit_o,
  output logic              data_hit_o,
  output logic              ident_write_lock_o,
  output logic [31:0]       system_setup_o
);
  import ssid_regs_pkg::*;

  typedef struct packed {
    logic [15:0]            subsys_vendor;
    logic [15:0]            subsys_ident;
    logic [31:0]            legacy_base;
    logic [31:0]            system_setup;
    logic [SYNC_STAGES-1:0] present_sync;
    logic                   present;
    logic                   ack;
    logic [31:0]            rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    subsys_vendor: SUBSYS_VENDOR_RESET,
    subsys_ident:  SUBSYS_IDENT_RESET,
    legacy_base:   LEGACY_BASE_RESET,
    system_setup:  SYSTEM_SETUP_RESET,
    present_sync:  '0,
    present:       1'b0,
    ack:           1'b0,
    rdata:         32'h0000_0000
  };

  state_s      st;
  state_s      next_st;
  logic        wr_req;
  logic        rd_req;
  logic        hit_ident;
  logic        hit_base;
  logic        hit_setup;
  logic        lock;
  logic [31:0] ident_word;
  logic [31:0] ident_merged;
  logic [31:0] read_mux;

  legacy_decode_if dec_if ();

  assign wr_req     = cfg_req_i && cfg_write_i;
  assign rd_req     = cfg_req_i && !cfg_write_i;
  // function number ignored: both functions see one copy of every register here
  assign hit_ident  = dword_hit(cfg_offset_i, OFF_SUBSYS_IDENT_WORD);
  assign hit_base   = dword_hit(cfg_offset_i, OFF_LEGACY_BASE);
  assign hit_setup  = dword_hit(cfg_offset_i, OFF_SYSTEM_SETUP);
  assign lock       = st.system_setup[IDENT_WRITE_LOCK_BIT];
  assign ident_word = {st.subsys_ident, st.subsys_vendor};
  // lock turns the whole identity dword read-only
  assign ident_merged = merge_bytes(ident_word, cfg_wdata_i, cfg_be_i,
                                    lock ? 32'h0000_0000 : ALL_BITS_WMASK);

  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_ident) begin
      read_mux = ident_word;
    end else if (hit_base) begin
      read_mux = st.legacy_base;
    end else if (hit_setup) begin
      read_mux = st.system_setup;
    end
  end

  always_comb begin
    next_st = st;

    // eeprom_present is a pin; the first stage feeds only the second
    next_st.present_sync = {st.present_sync[SYNC_STAGES-2:0], eeprom_present_i};
    if (st.present_sync[1] == st.present_sync[2]) begin
      next_st.present = st.present_sync[2];
    end

    next_st.ack   = cfg_req_i;
    next_st.rdata = rd_req ? read_mux : 32'h0000_0000;

    if (wr_req && hit_ident) begin
      next_st.subsys_vendor = ident_merged[15:0];
      next_st.subsys_ident  = ident_merged[31:16];
    end
    if (wr_req && hit_base) begin
      next_st.legacy_base = merge_bytes(st.legacy_base, cfg_wdata_i, cfg_be_i,
                                        LEGACY_BASE_WMASK);
    end
    if (wr_req && hit_setup) begin
      // read-only bits keep their value, the cycle still completes
      next_st.system_setup = merge_bytes(st.system_setup, cfg_wdata_i, cfg_be_i,
                                         SYSTEM_SETUP_WMASK);
    end
    next_st.legacy_base[LEGACY_FIXED_BIT] = 1'b1;

    // eeprom contents win over a same-cycle host write
    if (eeprom_load_i && st.present) begin
      next_st.subsys_vendor = eeprom_vendor_i;
      next_st.subsys_ident  = eeprom_ident_i;
    end
  end

  // rst_i is the global reset; no other reset reaches these flops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dec_if.base     = st.legacy_base;
  assign dec_if.io_addr  = io_addr_i;
  assign dec_if.io_valid = io_valid_i;

  legacy_io_decode u_decode (
    .dec (dec_if.decoder)
  );

  assign index_hit_o        = dec_if.index_hit;
  assign data_hit_o         = dec_if.data_hit;
  assign cfg_ack_o          = st.ack;
  assign cfg_rdata_o        = st.rdata;
  assign ident_write_lock_o = lock;
  assign system_setup_o     = st.system_setup;

  // assertion helpers
  logic seen_clock;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_clock <= 1'b0;
    end else begin
      seen_clock <= 1'b1;
    end
  end

  sequence ident_write_s;
    cfg_req_i && cfg_write_i && hit_ident && (cfg_be_i == 4'hf) && !eeprom_load_i;
  endsequence

  sequence setup_read_s;
    cfg_req_i && !cfg_write_i && hit_setup;
  endsequence

  sequence base_read_s;
    cfg_req_i && !cfg_write_i && hit_base;
  endsequence

  chk_locked_ident_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (lock && !(eeprom_load_i && st.present)) |=>
      ($stable(st.subsys_vendor) && $stable(st.subsys_ident)))
    else $error("identity changed while write lock set");

  chk_unlocked_ident_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ident_write_s and !lock) |=>
      ({st.subsys_ident, st.subsys_vendor} == $past(cfg_wdata_i)))
    else $error("unlocked identity write not stored");

  chk_lock_after_reset: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !seen_clock |-> (lock && st.subsys_vendor == SUBSYS_VENDOR_RESET &&
                     st.subsys_ident == SUBSYS_IDENT_RESET))
    else $error("lock or identity wrong after reset");

  chk_eeprom_load: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (eeprom_load_i && st.present) |=>
      (st.subsys_ident == $past(eeprom_ident_i) && st.subsys_vendor == $past(eeprom_vendor_i)))
    else $error("eeprom identity not loaded");

  chk_index_decode: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (io_valid_i && io_addr_i == {st.legacy_base[31:1], 1'b0}) |-> (index_hit_o && !data_hit_o))
    else $error("index address not decoded");

  chk_data_decode: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (io_valid_i && io_addr_i == {st.legacy_base[31:1], 1'b1}) |-> (data_hit_o && !index_hit_o))
    else $error("data address not decoded");

  chk_base_bit_one: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    base_read_s |=> (cfg_ack_o && cfg_rdata_o[0] && cfg_rdata_o == st.legacy_base))
    else $error("legacy base read wrong");

  chk_shared_base: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_req_i && cfg_write_i && hit_base && cfg_be_i == 4'hf) |=>
      (st.legacy_base == {$past(cfg_wdata_i[31:1]), 1'b1}))
    else $error("base write from either function not stored");

  chk_setup_read: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    setup_read_s |=> (cfg_ack_o && cfg_rdata_o == st.system_setup))
    else $error("system setup read wrong");

  chk_setup_ro_bits: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (st.system_setup & ~SYSTEM_SETUP_WMASK) == (SYSTEM_SETUP_RESET & ~SYSTEM_SETUP_WMASK))
    else $error("read-only setup bit changed");

  chk_ack_once: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cfg_req_i |=> cfg_ack_o)
    else $error("config cycle not acknowledged");

endmodule

// File: tb/cfg_host_model.sv
`timescale 1ns/10ps
module cfg_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             write_o,
  output logic             func_o,
  output logic [7:0]       offset_o,
  output logic [3:0]       be_o,
  output logic [31:0]      wdata_o
);
  initial begin
    req_o = 1'b0;
    write_o = 1'b0;
    func_o = 1'b0;
    offset_o = 8'h00;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  // one access per call; answer sampled at the negedge after the taking edge
  task automatic xfer(input logic w, input logic f, input logic [7:0] off,
                      input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] rd, output logic ok);
    @(negedge clk_i);
    req_o = 1'b1;
    write_o = w;
    func_o = f;
    offset_o = off;
    be_o = b;
    wdata_o = d;
    @(negedge clk_i);
    ok = ack_i;
    rd = rdata_i;
    req_o = 1'b0;
    // idle lines show garbage so stale values cannot pass
    wdata_o = ~d;
    offset_o = ~off;
    be_o = ~b;
  endtask
endmodule

// File: tb/test_subsystem_ident_legacy_base_regs.sv
`timescale 1ns/10ps
module test_subsystem_ident_legacy_base_regs;
  import ssid_regs_pkg::*;
  logic        core_clk_i, rst_i, cfg_req_i, cfg_write_i, cfg_func_i, cfg_ack_o;
  logic [7:0]  cfg_offset_i;
  logic [3:0]  cfg_be_i, b;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, system_setup_o, v, d, base, setup, id;
  logic        eeprom_present_i, eeprom_load_i, io_valid_i, ok;
  logic        index_hit_o, data_hit_o, ident_write_lock_o;
  logic [15:0] eeprom_vendor_i, eeprom_ident_i;
  logic [31:0] io_addr_i;
  int          errors, checks_done;

  subsystem_ident_legacy_base_regs u_subsystem_ident_legacy_base_regs (.core_clk_i, .rst_i,
    .cfg_req_i, .cfg_write_i, .cfg_func_i, .cfg_offset_i, .cfg_be_i, .cfg_wdata_i,
    .cfg_ack_o, .cfg_rdata_o, .eeprom_present_i, .eeprom_load_i, .eeprom_vendor_i,
    .eeprom_ident_i, .io_valid_i, .io_addr_i, .index_hit_o, .data_hit_o,
    .ident_write_lock_o, .system_setup_o);
  cfg_host_model u_cfg_host_model (.clk_i(core_clk_i), .ack_i(cfg_ack_o),
    .rdata_i(cfg_rdata_o), .req_o(cfg_req_i), .write_o(cfg_write_i), .func_o(cfg_func_i),
    .offset_o(cfg_offset_i), .be_o(cfg_be_i), .wdata_o(cfg_wdata_i));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] w, logic [3:0] be,
                                      logic [31:0] m);
    for (int i = 0; i < 32; i++) if (be[i/8] && m[i]) o[i] = w[i];
    return o;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic acc(input logic w, input logic f, input logic [7:0] off,
                     input logic [3:0] be, input logic [31:0] wd);
    u_cfg_host_model.xfer(w, f, off, be, wd, v, ok);
    chk1("ack", 1'b1, ok);
  endtask
  task automatic do_reset;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    // presence pin needs its synchroniser filled before loads count
    repeat (5) @(negedge core_clk_i);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    errors++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    io_valid_i = 1'b0;
    io_addr_i = 32'h0;
    eeprom_present_i = 1'b1;
    eeprom_load_i = 1'b0;
    eeprom_vendor_i = 16'h0;
    eeprom_ident_i = 16'h0;
    errors = 0;
    checks_done = 0;
    void'($urandom(32'h73f1));
    do_reset();
    chk1("lock", 1'b1, ident_write_lock_o);
    for (int f = 0; f < 2; f++) begin
      acc(1'b0, f[0], OFF_SYSTEM_SETUP, 4'hf, 32'h0);
      chk("setup", 32'h0800_9060, v);
    end
    acc(1'b1, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, $urandom);
    acc(1'b0, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, 32'h0);
    chk("ident locked", {SUBSYS_IDENT_RESET, SUBSYS_VENDOR_RESET}, v);
    setup = 32'h0800_9060;
    id = {SUBSYS_IDENT_RESET, SUBSYS_VENDOR_RESET};
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      b = 4'($urandom);
      if (i == 0) begin
        d[5] = 1'b0;
        b[0] = 1'b1;
      end
      acc(1'b1, 1'b0, OFF_SYSTEM_SETUP, b, d);
      setup = mrg(setup, d, b, SYSTEM_SETUP_WMASK);
      acc(1'b0, 1'b0, OFF_SYSTEM_SETUP, 4'hf, 32'h0);
      chk("setup rw", setup, v);
      chk("setup out", setup, system_setup_o);
      chk1("lock", setup[5], ident_write_lock_o);
      d = $urandom;
      b = 4'($urandom);
      acc(1'b1, i[0], (i % 3 == 0) ? OFF_SUBSYS_IDENT : OFF_SUBSYS_VENDOR, b, d);
      if (!setup[5]) id = mrg(id, d, b, 32'hffff_ffff);
      acc(1'b0, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, 32'h0);
      chk("ident", id, v);
    end
    // corner: unlocked full-dword identity write through function 1
    acc(1'b1, 1'b0, OFF_SYSTEM_SETUP, 4'h1, 32'h0);
    id = $urandom;
    acc(1'b1, 1'b1, OFF_SUBSYS_IDENT, 4'hf, id);
    acc(1'b0, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, 32'h0);
    chk("ident unlocked", id, v);
    chk1("lock clear", 1'b0, ident_write_lock_o);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
      acc(1'b1, i[0], OFF_LEGACY_BASE, 4'hf, d);
      base = {d[31:1], 1'b1};
      acc(1'b0, !i[0], OFF_LEGACY_BASE, 4'hf, 32'h0);
      chk("base", base, v);
      for (int k = 0; k < 4; k++) begin
        @(negedge core_clk_i);
        io_valid_i = (k != 3);
        io_addr_i = (k == 0) ? {base[31:1], 1'b0} : (k == 2) ? base + 32'h2 : base;
        #1;
        chk1("index hit", k == 0, index_hit_o);
        chk1("data hit", k == 1, data_hit_o);
      end
    end
    acc(1'b1, 1'b0, OFF_SYSTEM_SETUP, 4'h1, 32'h20);
    eeprom_vendor_i = 16'($urandom);
    eeprom_ident_i = 16'($urandom);
    eeprom_load_i = 1'b1;
    @(negedge core_clk_i);
    eeprom_load_i = 1'b0;
    acc(1'b0, 1'b1, OFF_SUBSYS_IDENT, 4'hf, 32'h0);
    chk("eeprom ident", {eeprom_ident_i, eeprom_vendor_i}, v);
    // no eeprom attached: a load strobe must leave the identity alone
    id = v;
    eeprom_present_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    eeprom_vendor_i = ~eeprom_vendor_i;
    eeprom_ident_i = ~eeprom_ident_i;
    eeprom_load_i = 1'b1;
    @(negedge core_clk_i);
    eeprom_load_i = 1'b0;
    acc(1'b0, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, 32'h0);
    chk("no eeprom", id, v);
    eeprom_present_i = 1'b1;
    do_reset();
    acc(1'b0, 1'b0, OFF_SUBSYS_VENDOR, 4'hf, 32'h0);
    chk("ident reset", {SUBSYS_IDENT_RESET, SUBSYS_VENDOR_RESET}, v);
    acc(1'b0, 1'b0, OFF_LEGACY_BASE, 4'hf, 32'h0);
    chk("base reset", 32'h1, v);
    chk1("lock reset", 1'b1, ident_write_lock_o);
    end_sim();
  end
endmodule
